// ==== exposure_map.svh ====
`ifndef EXPOSURE_MAP_SVH
`define EXPOSURE_MAP_SVH

// ****************************************************
// Register addresses
// ****************************************************
`define A_MONO      8'h27
`define A_MODE      8'h29
`define A_EXP_LO    8'h2A
`define A_EXP_HI    8'h2C
`define A_KP1_LO    8'h30
`define A_KP1_HI    8'h32
`define A_KP2_LO    8'h33
`define A_KP2_HI    8'h35
`define A_SLOPES    8'h36
`define A_ODD_LO    8'h38
`define A_ODD_HI    8'h3A
`define A_FOT       8'h49
`define A_STATUS    8'h60
`define A_MEAS_LO   8'h61
`define A_MEAS_HI   8'h63

// ****************************************************
// Field positions
// ****************************************************
`define B_EXT       0
`define B_DUAL      1
`define B_MONO      0

// ****************************************************
// Reset values
// ****************************************************
`define R_MONO      1'h1
`define R_MODE      2'h0
`define R_EXP       24'h000800
`define R_KP        24'h000001
`define R_SLOPES    2'h1
`define R_FOT       8'h0A

// ****************************************************
// Timing
// ****************************************************
`define UNIT_CYCLES 129
`define FOT_NUM     43
`define FOT_DEN     100

`endif

// ==== exposure_pkg.sv ====
package exposure_pkg;
    typedef logic [7:0]  byte_t;
    typedef logic [23:0] count_t;
    typedef logic [1:0]  clip_t;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_EXT_WAIT,
        ST_RUN
    } seq_state_t;
endpackage : exposure_pkg

// ==== exposure_timer.sv ====
`include "exposure_map.svh"

module exposure_timer #(
    parameter int UNIT = `UNIT_CYCLES
) (
    input  wire logic              clk,       // Master clock.
    input  wire logic              reset,     // Async reset, high.
    input  wire logic              start,     // Load and run, pulse.
    input  wire exposure_pkg::count_t units,  // Whole units to run.
    input  wire exposure_pkg::count_t tail,   // Overhead cycles, >= 1.
    output exposure_pkg::count_t   remaining, // Units still to run.
    output logic                   in_tail,   // Overhead phase.
    output logic                   busy,      // Timer running.
    output logic                   done       // End pulse.
);
    import exposure_pkg::*;

    localparam int PW = $clog2(UNIT);

    if (UNIT < 2) begin : g_check
        $error("exposure_timer: UNIT must be at least 2");
    end

    logic [PW-1:0] pre_q;
    count_t        rem_q;
    count_t        tail_q;
    logic          busy_q;
    logic          tail_ph_q;
    logic          done_q;
    wire           unit_tick = (pre_q == '0);
    wire           tail_last = (tail_q <= 24'h000001);

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pre_q     <= '0;
            rem_q     <= '0;
            tail_q    <= '0;
            busy_q    <= 1'b0;
            tail_ph_q <= 1'b0;
            done_q    <= 1'b0;
        end else begin
            done_q <= 1'b0;
            if (start && !busy_q) begin
                busy_q    <= 1'b1;
                rem_q     <= units;
                tail_q    <= tail;
                pre_q     <= PW'(UNIT - 1);
                tail_ph_q <= (units == '0);
            end else if (busy_q && !tail_ph_q) begin
                pre_q <= unit_tick ? PW'(UNIT - 1) : pre_q - 1'b1;
                if (unit_tick) begin
                    rem_q     <= rem_q - 1'b1;
                    tail_ph_q <= (rem_q == 24'h000001);
                end
            end else if (busy_q) begin
                tail_q <= tail_q - 1'b1;
                if (tail_last) begin
                    busy_q    <= 1'b0;
                    tail_ph_q <= 1'b0;
                    done_q    <= 1'b1;
                end
            end
        end
    end

    assign remaining = rem_q;
    assign in_tail   = tail_ph_q;
    assign busy      = busy_q;
    assign done      = done_q;
endmodule : exposure_timer

// ==== exposure_hdr_control.sv ====
// Functional notes
// - Mode bit 0 picks programmed count (0) or pin-measured exposure (1).
// - External: pin one rise starts, frame request rise ends exposure.
// - Internal: 129 clocks times (0.43 overhead plus count); count 24 bits.
// - Overhead length comes from its own register for every calculation.
// - External total is 129 x 0.43 x overhead plus measured interval.
// - External interval may be as short as one clock.
// - All high dynamic range modes work in internal and external mode with dual off.
// - Dual enable bit, reset 0, gives odd and even rows own times.
// - Dual internal: even rows timed from the primary count.
// - Dual internal: odd rows timed from second 24-bit count, reset 2048.
// - Dual external: pin one times even rows, pin two odd rows.
// - Colour select resets to mono; colour makes rows pair for Bayer.
// - Clipping level changes up to twice, at most three slopes.
// - Bright pixels clamped twice in sequence; dark pixels untouched.
// - Internal kneepoint timing follows programmed kneepoint counts; external steps on pin two rises.
// - Slope count field, 2 bits, valid 1 to 3, reset 1.
//
// Design decision made here: the plain strobed port.
`include "exposure_map.svh"

module exposure_hdr_control (
    input  wire logic                clk,          // Master clock.
    input  wire logic                reset,        // Async reset, high.
    input  wire exposure_pkg::byte_t addr,         // Register address.
    input  wire exposure_pkg::byte_t wdata,        // Write data.
    input  wire logic                wr_en,        // Write strobe.
    input  wire logic                rd_en,        // Read strobe.
    output exposure_pkg::byte_t      rdata,        // Read data, next cycle.
    input  wire logic                exposure_pin_one, // Even/all start.
    input  wire logic                exposure_pin_two, // Odd start.
    input  wire logic                frame_request,    // Frame request pin.
    output logic                     integrate_even,   // Even rows expose.
    output logic                     integrate_odd,    // Odd rows expose.
    output logic                     overhead_active,  // Overhead phase.
    output exposure_pkg::clip_t      clip_stage,   // 0 none, 1 and 2 clamp.
    output logic                     exposure_done,    // End pulse.
    output logic                     bayer_pairs   // Colour row pairing.
);
    import exposure_pkg::*;

    // ****************************************************
    // Helpers
    // ****************************************************
    function automatic count_t put_byte(count_t v, logic [1:0] lane,
                                        byte_t b);
        count_t r;
        r = v;
        r[8*lane +: 8] = b;
        return r;
    endfunction : put_byte

    // Overhead cycles are truncated; zero is lifted to one cycle.
    function automatic count_t ovh_cycles(byte_t fot);
        count_t p;
        p = 24'(fot) * 24'(`UNIT_CYCLES * `FOT_NUM);
        p = p / 24'(`FOT_DEN);
        return (p == '0) ? 24'h000001 : p;
    endfunction : ovh_cycles

    // A slope field of zero behaves as a single slope.
    function automatic clip_t slopes_eff(clip_t s);
        return (s == 2'h0) ? 2'h1 : s;
    endfunction : slopes_eff

    // ****************************************************
    // Register file
    // ****************************************************
    logic       mono_q;
    logic [1:0] mode_q;
    count_t     exp_q;
    count_t     odd_q;
    count_t     kp1_q;
    count_t     kp2_q;
    clip_t      slopes_q;
    byte_t      fot_q;
    byte_t      rdata_q;
    byte_t      rd_mux;

    wire in_exp = addr >= `A_EXP_LO && addr <= `A_EXP_HI;
    wire in_odd = addr >= `A_ODD_LO && addr <= `A_ODD_HI;
    wire in_kp1 = addr >= `A_KP1_LO && addr <= `A_KP1_HI;
    wire in_kp2 = addr >= `A_KP2_LO && addr <= `A_KP2_HI;
    wire in_mea = addr >= `A_MEAS_LO && addr <= `A_MEAS_HI;
    wire [1:0] ln_exp = 2'(addr - `A_EXP_LO);
    wire [1:0] ln_odd = 2'(addr - `A_ODD_LO);
    wire [1:0] ln_kp1 = 2'(addr - `A_KP1_LO);
    wire [1:0] ln_kp2 = 2'(addr - `A_KP2_LO);
    wire [1:0] ln_mea = 2'(addr - `A_MEAS_LO);

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            mono_q   <= `R_MONO;
            mode_q   <= `R_MODE;
            exp_q    <= `R_EXP;
            odd_q    <= `R_EXP;
            kp1_q    <= `R_KP;
            kp2_q    <= `R_KP;
            slopes_q <= `R_SLOPES;
            fot_q    <= `R_FOT;
        end else if (wr_en) begin
            if (addr == `A_MONO) mono_q <= wdata[`B_MONO];
            if (addr == `A_MODE) mode_q <= wdata[1:0];
            if (addr == `A_SLOPES) slopes_q <= wdata[1:0];
            if (addr == `A_FOT) fot_q <= wdata;
            if (in_exp) exp_q <= put_byte(exp_q, ln_exp, wdata);
            if (in_odd) odd_q <= put_byte(odd_q, ln_odd, wdata);
            if (in_kp1) kp1_q <= put_byte(kp1_q, ln_kp1, wdata);
            if (in_kp2) kp2_q <= put_byte(kp2_q, ln_kp2, wdata);
        end
    end

    wire ext_q  = mode_q[`B_EXT];
    wire dual_q = mode_q[`B_DUAL];

    // ****************************************************
    // Pin edges
    // ****************************************************
    logic p1_q;
    logic p2_q;
    logic fr_q;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            p1_q <= 1'b0;
            p2_q <= 1'b0;
            fr_q <= 1'b0;
        end else begin
            p1_q <= exposure_pin_one;
            p2_q <= exposure_pin_two;
            fr_q <= frame_request;
        end
    end

    wire p1_rise = exposure_pin_one && !p1_q;
    wire p2_rise = exposure_pin_two && !p2_q;
    wire fr_rise = frame_request && !fr_q;

    // ****************************************************
    // Sequencer
    // ****************************************************
    seq_state_t state_q;
    seq_state_t state_d;
    count_t     meas_q;
    logic       odd_run_q;
    clip_t      clip_ext_q;
    count_t     t_rem;
    logic       t_tail;
    logic       t_busy;
    logic       t_done;

    // The run timer is sized by the longer parity; the shorter one opens
    // later so that both close together at the overhead phase.
    wire count_t odd_eff = dual_q ? odd_q : exp_q;
    wire count_t int_units = (odd_eff > exp_q) ? odd_eff : exp_q;
    wire int_go = state_q == ST_IDLE && !ext_q && fr_rise;
    wire ext_go = state_q == ST_IDLE && ext_q && p1_rise;
    wire ext_end = state_q == ST_EXT_WAIT && fr_rise;
    wire t_start = int_go || ext_end;
    wire count_t t_units = ext_end ? 24'h000000 : int_units;
    wire count_t t_tail_len = ovh_cycles(fot_q);

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE: begin
                if (int_go) state_d = ST_RUN;
                else if (ext_go) state_d = ST_EXT_WAIT;
            end
            ST_EXT_WAIT: begin
                if (ext_end) state_d = ST_RUN;
            end
            ST_RUN: begin
                if (t_done) state_d = ST_IDLE;
            end
        endcase
    end

    exposure_timer #(
        .UNIT (`UNIT_CYCLES)
    ) u_timer (
        .clk       (clk),
        .reset     (reset),
        .start     (t_start),
        .units     (t_units),
        .tail      (t_tail_len),
        .remaining (t_rem),
        .in_tail   (t_tail),
        .busy      (t_busy),
        .done      (t_done)
    );

    wire meas_full = &meas_q;
    wire s3 = slopes_eff(slopes_q) == 2'h3;
    wire s2 = slopes_eff(slopes_q) >= 2'h2;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_q    <= ST_IDLE;
            meas_q     <= '0;
            odd_run_q  <= 1'b0;
            clip_ext_q <= 2'h0;
        end else begin
            state_q <= state_d;
            if (ext_go) begin
                meas_q     <= '0;
                odd_run_q  <= 1'b0;
                clip_ext_q <= (s2 && !dual_q) ? 2'h1 : 2'h0;
            end else if (state_q == ST_EXT_WAIT) begin
                if (!meas_full) meas_q <= meas_q + 1'b1;
                if (p2_rise && dual_q) odd_run_q <= 1'b1;
                if (p2_rise && !dual_q) begin
                    clip_ext_q <= (clip_ext_q == 2'h1 && s3)
                                  ? 2'h2 : 2'h0;
                end
            end
        end
    end

    // ****************************************************
    // Row exposure and clamp phases
    // ****************************************************
    wire int_run = state_q == ST_RUN && t_busy && !t_tail && t_rem != '0;
    wire int_ph  = int_run && !ext_q;
    wire ext_ph  = state_q == ST_EXT_WAIT;
    wire even_d  = (int_ph && t_rem <= exp_q) || ext_ph;
    wire odd_int = int_ph && t_rem <= odd_eff;
    wire odd_ext = ext_ph && (!dual_q || odd_run_q);
    wire odd_d   = odd_int || odd_ext;

    // Dual rows and clamping cannot be combined, so dual forces no clamp.
    clip_t clip_int;
    assign clip_int = (!int_ph || dual_q) ? 2'h0 :
                      (s2 && t_rem > kp1_q) ? 2'h1 :
                      (s3 && t_rem > kp2_q) ? 2'h2 : 2'h0;
    wire clip_t clip_d = ext_q ? (ext_ph ? clip_ext_q : 2'h0) : clip_int;

    logic  integrate_even_q;
    logic  integrate_odd_q;
    logic  overhead_q;
    clip_t clip_stage_q;
    logic  done_q;
    logic  bayer_q;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            integrate_even_q <= 1'b0;
            integrate_odd_q  <= 1'b0;
            overhead_q       <= 1'b0;
            clip_stage_q     <= 2'h0;
            done_q           <= 1'b0;
            bayer_q          <= 1'b0;
        end else begin
            integrate_even_q <= even_d;
            integrate_odd_q  <= odd_d;
            overhead_q       <= t_tail;
            clip_stage_q     <= clip_d;
            done_q           <= t_done;
            bayer_q          <= !mono_q;
        end
    end

    // ****************************************************
    // Read path
    // ****************************************************
    wire byte_t status = {2'h0, t_tail, clip_stage_q, integrate_odd_q,
                          integrate_even_q, t_busy};

    always_comb begin
        rd_mux = 8'h00;
        if (addr == `A_MONO) rd_mux = {7'h00, mono_q};
        if (addr == `A_MODE) rd_mux = {6'h00, mode_q};
        if (addr == `A_SLOPES) rd_mux = {6'h00, slopes_q};
        if (addr == `A_FOT) rd_mux = fot_q;
        if (addr == `A_STATUS) rd_mux = status;
        if (in_exp) rd_mux = exp_q[8*ln_exp +: 8];
        if (in_odd) rd_mux = odd_q[8*ln_odd +: 8];
        if (in_kp1) rd_mux = kp1_q[8*ln_kp1 +: 8];
        if (in_kp2) rd_mux = kp2_q[8*ln_kp2 +: 8];
        if (in_mea) rd_mux = meas_q[8*ln_mea +: 8];
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) rdata_q <= 8'h00;
        else rdata_q <= rd_en ? rd_mux : 8'h00;
    end

    assign rdata           = rdata_q;
    assign integrate_even  = integrate_even_q;
    assign integrate_odd   = integrate_odd_q;
    assign overhead_active = overhead_q;
    assign clip_stage      = clip_stage_q;
    assign exposure_done   = done_q;
    assign bayer_pairs     = bayer_q;

    // ****************************************************
    // Checks
    // ****************************************************
    count_t tail_seen_q;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) tail_seen_q <= '0;
        else if (t_start) tail_seen_q <= '0;
        else if (t_tail) tail_seen_q <= tail_seen_q + 1'b1;
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    sequence s_ext_open;
        state_q == ST_IDLE && ext_q && p1_rise;
    endsequence
    sequence s_fast_close;
        fr_rise;
    endsequence

    a_ext_start_wait: assert property (s_ext_open |=>
        state_q == ST_EXT_WAIT ##1 integrate_even_q)
        else $error("external start did not open exposure");
    a_ext_short_gap: assert property (s_ext_open ##1 s_fast_close |=>
        state_q == ST_RUN ##1 overhead_q && !integrate_even_q)
        else $error("one-cycle external interval not accepted");
    a_ext_meas_count: assert property (ext_end && !meas_full |=>
        meas_q == $past(meas_q) + 24'h000001)
        else $error("measured interval count wrong");
    a_int_start_run: assert property (int_go |=>
        state_q == ST_RUN && t_rem == $past(int_units))
        else $error("internal start did not load count");
    a_tail_length: assert property (t_done |->
        tail_seen_q == ovh_cycles(fot_q))
        else $error("overhead length wrong");
    a_single_rows_same: assert property (!dual_q && !$past(dual_q) |->
        integrate_odd_q == integrate_even_q)
        else $error("rows differ with dual off");
    a_odd_row_window: assert property (
        $past(int_ph) && $past(dual_q) && integrate_odd_q |->
        $past(t_rem) <= $past(odd_q))
        else $error("odd rows exposed outside their window");
    a_clip_slope_max: assert property (clip_stage_q == 2'h2 |->
        $past(s3) && !$past(dual_q))
        else $error("third slope without three slopes");
    a_done_one_cycle: assert property ($rose(exposure_done) |=>
        !exposure_done && state_q == ST_IDLE)
        else $error("done pulse too long");
endmodule : exposure_hdr_control

// ==== exposure_host_model.sv ====
module exposure_host_model (
    input  wire logic clk,       // Master clock.
    output logic      pin_one,   // Exposure start, even or all rows.
    output logic      pin_two,   // Odd-row start or clamp step.
    output logic      frame_req  // Frame request.
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        pin_one   = 1'b0;
        pin_two   = 1'b0;
        frame_req = 1'b0;
    end

    // ****************************************************
    // Internal mode: a lone frame request starts the exposure.
    // ****************************************************
    task automatic frame_pulse();
        @(posedge clk);
        frame_req <= 1'b1;
        @(posedge clk);
        frame_req <= 1'b0;
    endtask : frame_pulse

    // ****************************************************
    // External mode: the pins are driven low again once the frame
    // request is seen, so that every run starts from a clean edge.
    // A value of p2 of zero leaves the second pin alone.
    // ****************************************************
    task automatic expose_ext(input int n, input int p2);
        int i;
        @(posedge clk);
        pin_one <= 1'b1;
        for (i = 1; i <= n; i++) begin
            @(posedge clk);
            if (i == p2) pin_two <= 1'b1;
            if (i == n) frame_req <= 1'b1;
        end
        @(posedge clk);
        pin_one   <= 1'b0;
        pin_two   <= 1'b0;
        frame_req <= 1'b0;
    endtask : expose_ext
endmodule : exposure_host_model

// ==== exposure_hdr_control_tb.sv ====
`include "exposure_map.svh"

module exposure_hdr_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import exposure_pkg::*;

    logic  clk;
    logic  reset;
    byte_t addr;
    byte_t wdata;
    logic  wr_en;
    logic  rd_en;
    byte_t rdata;
    logic  pin_one;
    logic  pin_two;
    logic  frame_req;
    logic  integrate_even;
    logic  integrate_odd;
    logic  overhead_active;
    clip_t clip_stage;
    logic  exposure_done;
    logic  bayer_pairs;
    int    errors;
    int    checks;
    int    n_even;
    int    n_odd;
    int    n_ovh;
    int    max_clip;
    byte_t rv;
    // Overhead register is set to 1: floor(1 * 129 * 43 / 100) cycles.
    localparam int OVH = 55;
    localparam int U   = 129;
    byte_t ra [11] = '{8'h27, 8'h29, 8'h2A, 8'h2B, 8'h2C, 8'h36,
                       8'h38, 8'h39, 8'h3A, 8'h49, 8'h10};
    byte_t re [11] = '{8'h01, 8'h00, 8'h00, 8'h08, 8'h00, 8'h01,
                       8'h00, 8'h08, 8'h00, 8'h0A, 8'h00};

    exposure_hdr_control i_dut (
        .clk(clk), .reset(reset), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
        .exposure_pin_one(pin_one), .exposure_pin_two(pin_two),
        .frame_request(frame_req), .integrate_even(integrate_even),
        .integrate_odd(integrate_odd), .overhead_active(overhead_active),
        .clip_stage(clip_stage), .exposure_done(exposure_done),
        .bayer_pairs(bayer_pairs)
    );

    exposure_host_model i_host (
        .clk(clk), .pin_one(pin_one), .pin_two(pin_two),
        .frame_req(frame_req)
    );

    always #20 clk = ~clk;

    // ****************************************************
    // Bus tasks and comparison
    // ****************************************************
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check

    task automatic wr(input byte_t a, input byte_t d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask : wr

    task automatic rd(input byte_t a, output byte_t d);
        @(posedge clk);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        d = rdata;
    endtask : rd

    task automatic end_of_test();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_of_test

    // Counts even, odd and overhead active cycles until the end pulse; the bound
    // keeps a design that never finishes from hanging the run.
    task automatic watch();
        int i;
        bit seen;
        n_even   = 0;
        n_odd    = 0;
        n_ovh    = 0;
        max_clip = 0;
        seen     = 0;
        for (i = 0; i < 3000 && !seen; i++) begin
            @(negedge clk);
            if (integrate_even === 1'b1) n_even++;
            if (integrate_odd === 1'b1) n_odd++;
            if (overhead_active === 1'b1) n_ovh++;
            if (clip_stage === 2'h1 && max_clip < 1) max_clip = 1;
            if (clip_stage === 2'h2) max_clip = 2;
            if (exposure_done === 1'b1) seen = 1;
        end
        if (!seen) begin
            check(24'h000000, 24'h000001);
            end_of_test();
        end
        repeat (3) @(negedge clk);
    endtask : watch

    task automatic run_int();
        fork
            i_host.frame_pulse();
            watch();
        join
    endtask : run_int

    task automatic run_ext(input int n, input int p2);
        fork
            i_host.expose_ext(n, p2);
            watch();
        join
    endtask : run_ext

    // ****************************************************
    // Main sequence
    // ****************************************************
    initial begin
        clk    = 1'b0;
        reset  = 1'b1;
        addr   = 8'h00;
        wdata  = 8'h00;
        wr_en  = 1'b0;
        rd_en  = 1'b0;
        errors = 0;
        checks = 0;
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        for (int k = 0; k < 11; k++) begin
            rd(ra[k], rv);
            check(rv, re[k]);
        end
        $display("test reset values done");

        wr(`A_FOT, 8'h01);
        wr(`A_EXP_LO, 8'h02);
        wr(`A_EXP_LO + 8'h01, 8'h00);
        rd(`A_EXP_LO, rv);
        check(rv, 8'h02);
        run_int();
        check(n_even, 2 * U);
        check(n_odd, 2 * U);
        check(n_ovh, OVH);
        check(max_clip, 0);
        $display("test internal done");

        wr(`A_MODE, 8'h02);
        wr(`A_ODD_LO, 8'h03);
        wr(`A_ODD_LO + 8'h01, 8'h00);
        run_int();
        check(n_even, 2 * U);
        check(n_odd, 3 * U);
        check(n_ovh, OVH);
        $display("test internal dual done");

        wr(`A_MODE, 8'h00);
        wr(`A_EXP_LO, 8'h03);
        wr(`A_KP1_LO, 8'h02);
        wr(`A_KP2_LO, 8'h01);
        wr(`A_SLOPES, 8'h03);
        run_int();
        check(max_clip, 2);
        check(clip_stage, 2'h0);
        $display("test internal slopes done");

        wr(`A_MODE, 8'h01);
        run_ext(1, 0);
        check(n_even, 1);
        check(n_ovh, OVH);
        check(max_clip, 1);
        rd(`A_MEAS_LO, rv);
        check(rv, 8'h01);
        run_ext(20, 8);
        check(n_even, 20);
        check(max_clip, 2);
        rd(`A_MEAS_LO, rv);
        check(rv, 8'h14);
        wr(`A_MEAS_LO, 8'hFF);
        rd(`A_MEAS_LO, rv);
        check(rv, 8'h14);
        $display("test external done");

        wr(`A_MODE, 8'h03);
        run_ext(20, 8);
        check(n_even, 20);
        check(n_odd, 12);
        check(n_ovh, OVH);
        $display("test external dual done");

        wr(`A_MONO, 8'h00);
        rd(`A_MONO, rv);
        check(rv, 8'h00);
        repeat (2) @(negedge clk);
        check(bayer_pairs, 1'b1);
        $display("test colour select done");
        end_of_test();
    end
endmodule : exposure_hdr_control_tb
